/* shared/mesc_pkg.sv */
// Purpose: constants and carriers of the engine status/config bank
// Assumes: 32-bit engine data words, word-addressed engine memory
// Notes:   offsets are engine data word addresses
package mesc_pkg;
	localparam logic [7:0]  CFG_ADDR      = 8'h20;
	localparam logic [7:0]  THR_ADDR      = 8'h24;
	localparam logic [7:0]  RATE_ADDR     = 8'h28;
	localparam logic [7:0]  GAIN_ADDR     = 8'h40;
	localparam logic [7:0]  STAT_ADDR     = 8'h80;
	localparam logic [31:0] CFG_RESET     = 32'h0000_5020;
	localparam logic [31:0] THR_RESET     = 32'h0006_c278;
	localparam logic [31:0] GAIN_RESET    = 32'h0000_4000;
	localparam int          CFG_DIP_B_EN  = 19;
	localparam int          CFG_DIP_A_EN  = 18;
	localparam int          CFG_DIP_IRQ   = 17;
	localparam int          CFG_PROCESSOR_TEMP_COMP  = 16;
	localparam int          CFG_CNT_HI    = 15;
	localparam int          CFG_CNT_LO    = 8;
	localparam int          CFG_PICK_HI   = 7;
	localparam int          CFG_PICK_LO   = 6;
	localparam int          CFG_PROCESSOR_PULSE_SOURCE = 5;
	localparam int          CFG_B_X8      = 3;
	localparam int          CFG_A_X8      = 2;
	localparam int          CFG_FAST      = 1;
	localparam int          CFG_SLOW      = 0;
	localparam int          ST_F0         = 28;
	localparam int          ST_DIP_B      = 26;
	localparam int          ST_DIP_A      = 25;
	localparam int          FAST_SHIFT    = 4;
	localparam int          SLOW_SHIFT    = 6;
	localparam int          LIN_SHIFT     = 8;
	localparam int          QUAD_SHIFT    = 16;
	localparam logic [3:0]  GAIN_X8       = 4'h8;
	localparam logic [3:0]  GAIN_X1       = 4'h1;
	localparam logic [2:0]  FORMULA_ONE   = 3'h0;
	localparam logic [2:0]  FORMULA_TWO   = 3'h2;

	typedef logic [3:0][31:0] mesc_pulse_t;

	typedef struct packed {
		logic signed [31:0] w0;
		logic signed [31:0] w1;
		logic signed [31:0] var0;
		logic signed [31:0] var1;
		logic        [31:0] i0sq;
		logic        [31:0] i1sq;
	} mesc_sums_t;

	typedef struct packed {
		logic [31:0]      cfg;
		logic [31:0]      thr;
		logic [31:0]      gain;
		logic [31:0]      status;
		mesc_pulse_t      rate;
		mesc_pulse_t      pls;
		logic [1:0][7:0]  cnt;
		logic [1:0]       dip;
		logic             f0;
		logic [31:0]      rdata;
		logic             aux;
		logic             pll_b;
		logic [3:0]       gain_a;
		logic [3:0]       gain_b;
	} mesc_state_t;
endpackage : mesc_pkg

/* core/mesc_bank.sv */
// Purpose: engine status and configuration words with their effects
// Assumes: pass_end pulses once per code pass; smp_valid per sample
// Notes:   reads answer one cycle after mem_rd; status is read-only
//
// Behaviour
// - status word rewritten every pass end; dip counts and flags carry across passes.
// - status word lives at engine address 0x80.
// - status bits 31:29 and 24:0 always read zero.
// - bit 28 is a square wave at the picked phase's line frequency.
// - bit 26 sets after phase B dips long enough, clears above threshold.
// - bit 25 sets after phase A dips long enough, clears above threshold.
// - config word at address 0x20, reset value 0x5020.
// - shunt bit set gives that current channel a gain of eight.
// - external pulse bit feeds pulse generators from processor rates.
// - formula 2 feeds summed watts and summed vars.
// - formula 0 feeds the element with larger squared current.
// - bit 16 clear lets the engine own the scale word.
// - loop locks to the phase chosen by the pick bits.
// - bit 19 enables phase B dip interrupt, bit 18 phase A.
// - several enables set: interrupt only when all enabled phases dip.
// - bit 17 routes the dip interrupt onto the aux pulse pin.
// - pick bits 0/0 select phase A, 0/1 phase B.
// - fast bit multiplies the pulse generator input by sixteen.
module mesc_bank
	import mesc_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic [7:0]         mem_addr,
	input  wire logic               mem_wr,
	input  wire logic               mem_rd,
	input  wire logic [31:0]        mem_wdata,
	output logic      [31:0]        mem_rdata,
	input  wire logic               pass_end,
	input  wire logic               smp_valid,
	input  wire logic signed [31:0] volt_a,
	input  wire logic signed [31:0] volt_b,
	input  wire logic signed [15:0] temp_offset,
	input  wire logic signed [15:0] temp_coeff_linear,
	input  wire logic signed [15:0] temp_coeff_quadratic,
	input  wire mesc_sums_t         sums,
	input  wire logic [2:0]         meter_formula_select,
	input  wire logic               aux_pin_normal,
	output mesc_pulse_t             pulse_in,
	output logic [3:0]              cur_a_gain,
	output logic [3:0]              cur_b_gain,
	output logic                    pll_phase_b,
	output logic                    aux_pulse_output,
	output logic [31:0]             scale_factor_word
);
	mesc_state_t s_q;
	mesc_state_t s_d;

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction : mag

	// rate gain; fast and slow together are illegal, fast wins
	function automatic logic [31:0] pscale(input logic [31:0] v,
			input logic fast, input logic slow);
		if (fast)
			pscale = v << FAST_SHIFT;
		else if (slow)
			pscale = 32'($signed(v) >>> SLOW_SHIFT);
		else
			pscale = v;
	endfunction : pscale

	logic [1:0][31:0]   v_mag;
	logic [7:0]         dip_sample_count;
	logic               dip_irq;
	logic               pick_b;
	logic signed [63:0] comp;
	mesc_pulse_t        src;

	always_comb begin
		s_d = s_q;
		v_mag[0] = mag(volt_a);
		v_mag[1] = mag(volt_b);
		dip_sample_count = s_q.cfg[CFG_CNT_HI:CFG_CNT_LO];
		// low pick bit chooses phase B
		pick_b = s_q.cfg[CFG_PICK_LO];

		if (smp_valid) begin
			for (int p = 0; p < 2; p++) begin
				if (v_mag[p] < s_q.thr) begin
					if (s_q.cnt[p] != 8'hff)
						s_d.cnt[p] = s_q.cnt[p] + 8'h01;
					if (s_q.cnt[p] + 8'h01 >= dip_sample_count)
						s_d.dip[p] = 1'b1;
				end else if (v_mag[p] > s_q.thr) begin
					s_d.cnt[p] = 8'h00;
					s_d.dip[p] = 1'b0;
				end
			end
			// sign of picked phase gives the square wave
			s_d.f0 = pick_b ? ~volt_b[31] : ~volt_a[31];
		end

		// snapshot at pass end; dip counts and flags carry across passes
		if (pass_end) begin
			s_d.status = 32'h0;
			s_d.status[ST_F0] = s_q.f0;
			s_d.status[ST_DIP_B] = s_q.dip[1];
			s_d.status[ST_DIP_A] = s_q.dip[0];
		end

		// engine owns the scale word while bit 16 is clear
		comp = 64'(temp_coeff_linear * temp_offset) >>> LIN_SHIFT;
		comp = comp + (64'(temp_coeff_quadratic * temp_offset
			* temp_offset) >>> QUAD_SHIFT);
		if (pass_end && !s_q.cfg[CFG_PROCESSOR_TEMP_COMP])
			s_d.gain = GAIN_RESET + comp[31:0];

		// writes to the status word are dropped
		if (mem_wr) begin
			case (mem_addr)
				CFG_ADDR:  s_d.cfg = mem_wdata;
				THR_ADDR:  s_d.thr = mem_wdata;
				GAIN_ADDR: begin
					if (s_q.cfg[CFG_PROCESSOR_TEMP_COMP])
						s_d.gain = mem_wdata;
				end
				default: begin
					if (mem_addr[7:2] == RATE_ADDR[7:2])
						s_d.rate[mem_addr[1:0]] = mem_wdata;
				end
			endcase
		end

		// status decoded at its engine address
		if (mem_rd) begin
			case (mem_addr)
				CFG_ADDR:  s_d.rdata = s_q.cfg;
				THR_ADDR:  s_d.rdata = s_q.thr;
				GAIN_ADDR: s_d.rdata = s_q.gain;
				STAT_ADDR: s_d.rdata = s_q.status;
				default: begin
					if (mem_addr[7:2] == RATE_ADDR[7:2])
						s_d.rdata = s_q.rate[mem_addr[1:0]];
					else
						s_d.rdata = 32'h0;
				end
			endcase
		end

		// processor rates when external bit set
		// larger squared current for formula 0
		src = s_q.rate;
		if (!s_q.cfg[CFG_PROCESSOR_PULSE_SOURCE]) begin
			src[2] = 32'h0;
			src[3] = 32'h0;
			if (meter_formula_select == FORMULA_TWO) begin
				src[0] = 32'(sums.w0 + sums.w1);
				src[1] = 32'(sums.var0 + sums.var1);
			end else if (sums.i1sq > sums.i0sq) begin
				src[0] = sums.w1;
				src[1] = sums.var1;
			end else begin
				src[0] = sums.w0;
				src[1] = sums.var0;
			end
		end
		for (int k = 0; k < 4; k++)
			s_d.pls[k] = pscale(src[k], s_q.cfg[CFG_FAST],
				s_q.cfg[CFG_SLOW]);

		s_d.gain_a = s_q.cfg[CFG_A_X8] ? GAIN_X8 : GAIN_X1;
		s_d.gain_b = s_q.cfg[CFG_B_X8] ? GAIN_X8 : GAIN_X1;
		s_d.pll_b = pick_b;

		dip_irq = (s_q.cfg[CFG_DIP_A_EN] | s_q.cfg[CFG_DIP_B_EN])
			& (~s_q.cfg[CFG_DIP_A_EN] | s_q.dip[0])
			& (~s_q.cfg[CFG_DIP_B_EN] | s_q.dip[1]);
		// live level spares the processor per-pass polling
		s_d.aux = s_q.cfg[CFG_DIP_IRQ] ? dip_irq : aux_pin_normal;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.cfg <= CFG_RESET;
			s_q.thr <= THR_RESET;
			s_q.gain <= GAIN_RESET;
			s_q.gain_a <= GAIN_X1;
			s_q.gain_b <= GAIN_X1;
		end else begin
			s_q <= s_d;
		end
	end

	assign mem_rdata = s_q.rdata;
	assign pulse_in = s_q.pls;
	assign cur_a_gain = s_q.gain_a;
	assign cur_b_gain = s_q.gain_b;
	assign pll_phase_b = s_q.pll_b;
	assign aux_pulse_output = s_q.aux;
	assign scale_factor_word = s_q.gain;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_stat_zero;
		(s_q.status[31:29] == 3'h0) && (s_q.status[24:0] == 25'h0);
	endproperty
	a_stat_zero: assert property (p_stat_zero)
		else $error("unused status bits not zero");

	property p_rsvd_zero;
		mem_rd && mem_addr == STAT_ADDR |=> mem_rdata[27] == 1'b0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved status bit read nonzero");

	property p_pass_snap;
		pass_end |=> s_q.status[ST_DIP_A] == $past(s_q.dip[0])
			&& s_q.status[ST_DIP_B] == $past(s_q.dip[1])
			&& s_q.status[ST_F0] == $past(s_q.f0);
	endproperty
	a_pass_snap: assert property (p_pass_snap)
		else $error("status not taken from this pass");

	property p_dip_b_set;
		$rose(s_q.dip[1]) |-> $past(smp_valid)
			&& $past(v_mag[1]) < $past(s_q.thr);
	endproperty
	a_dip_b_set: assert property (p_dip_b_set)
		else $error("phase b dip set without low sample");

	property p_dip_a_clr;
		$fell(s_q.dip[0]) |-> $past(smp_valid)
			&& $past(v_mag[0]) > $past(s_q.thr);
	endproperty
	a_dip_a_clr: assert property (p_dip_a_clr)
		else $error("phase a dip cleared while low");

	property p_cfg_read;
		mem_rd && mem_addr == CFG_ADDR && !mem_wr
			|=> mem_rdata == $past(s_q.cfg);
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("config word read mismatch");

	property p_shunt;
		$rose(s_q.cfg[CFG_A_X8]) |=> cur_a_gain == GAIN_X8;
	endproperty
	a_shunt: assert property (p_shunt)
		else $error("channel a gain not eight");

	property p_aux_all;
		s_q.cfg[CFG_DIP_IRQ] && s_q.cfg[CFG_DIP_A_EN]
			&& s_q.cfg[CFG_DIP_B_EN] && !s_q.dip[0]
			|=> !aux_pulse_output;
	endproperty
	a_aux_all: assert property (p_aux_all)
		else $error("dip interrupt without all phases");

	property p_processor_pulse_source;
		s_q.cfg[CFG_PROCESSOR_PULSE_SOURCE] && s_q.cfg[1:0] == 2'b00
			|=> pulse_in[0] == $past(s_q.rate[0]);
	endproperty
	a_processor_pulse_source: assert property (p_processor_pulse_source)
		else $error("pulse not from processor rate");

	property p_own_gain;
		s_q.cfg[CFG_PROCESSOR_TEMP_COMP] && !mem_wr |=> $stable(scale_factor_word);
	endproperty
	a_own_gain: assert property (p_own_gain)
		else $error("engine changed processor-owned scale");
endmodule : mesc_bank

/* tb/mesc_cpu_model.sv */
// Purpose: processor side of the engine data memory
// Assumes: one word per strobe, strobes launched on the falling edge
// Notes:   idle write data shows the inverse of the last word
module mesc_cpu_model (
	input  wire logic        clk,
	output logic [7:0]       mem_addr,
	output logic             mem_wr,
	output logic             mem_rd,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		mem_addr  = 8'h00;
		mem_wr    = 1'b0;
		mem_rd    = 1'b0;
		mem_wdata = 32'h0000_0000;
	end

	// scale word written only while processor owns it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		mem_addr  = a;
		mem_wdata = d;
		mem_wr    = 1'b1;
		@(negedge clk);
		mem_wr    = 1'b0;
		mem_wdata = ~d;
	endtask : wr

	// data registered one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		mem_addr = a;
		mem_rd   = 1'b1;
		@(negedge clk);
		mem_rd   = 1'b0;
		d        = mem_rdata;
	endtask : rd
endmodule : mesc_cpu_model

/* tb/test_meter_engine_status_config.sv */
// Purpose: self-checking bench for the engine status/config bank
// Assumes: inputs change on the falling edge
// Notes:   derived outputs settle two cycles after a config write
module test_meter_engine_status_config
	import mesc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic signed [31:0] HI = 32'sh0007_a120;
	localparam logic signed [31:0] LO = 32'sh0000_0001;
	logic               clk;
	logic               resetn;
	logic               pass_end;
	logic               smp_valid;
	logic               aux_pin_normal;
	logic [7:0]         mem_addr;
	logic               mem_wr;
	logic               mem_rd;
	logic [31:0]        mem_wdata;
	logic [31:0]        mem_rdata;
	logic signed [31:0] volt_a;
	logic signed [31:0] volt_b;
	logic signed [15:0] temp_offset;
	logic signed [15:0] temp_coeff_linear;
	logic signed [15:0] temp_coeff_quadratic;
	logic [2:0]         meter_formula_select;
	mesc_sums_t         sums;
	mesc_pulse_t        pulse_in;
	logic [3:0]         cur_a_gain;
	logic [3:0]         cur_b_gain;
	logic               pll_phase_b;
	logic               aux_pulse_output;
	logic [31:0]        scale_factor_word;
	logic [31:0]        rd_q;
	int                 mismatches;
	int                 tests_run;

	mesc_bank mesc_bank_inst (.clk, .resetn, .mem_addr, .mem_wr, .mem_rd,
		.mem_wdata, .mem_rdata, .pass_end, .smp_valid, .volt_a, .volt_b,
		.temp_offset, .temp_coeff_linear, .temp_coeff_quadratic, .sums,
		.meter_formula_select, .aux_pin_normal, .pulse_in, .cur_a_gain,
		.cur_b_gain, .pll_phase_b, .aux_pulse_output, .scale_factor_word);

	mesc_cpu_model mesc_cpu_model_inst (.clk, .mem_addr, .mem_wr, .mem_rd,
		.mem_wdata, .mem_rdata);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask : settle

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		mesc_cpu_model_inst.rd(a, rd_q);
		chk(rd_q, exp);
	endtask : rdchk

	task automatic cfg(input logic [31:0] d);
		mesc_cpu_model_inst.wr(CFG_ADDR, d);
		settle();
	endtask : cfg

	task automatic smp(input logic signed [31:0] a, input logic signed [31:0] b);
		@(negedge clk);
		volt_a    = a;
		volt_b    = b;
		smp_valid = 1'b1;
		@(negedge clk);
		smp_valid = 1'b0;
	endtask : smp

	// pass end then status read back
	task automatic pass(input logic [31:0] exp);
		@(negedge clk);
		pass_end = 1'b1;
		@(negedge clk);
		pass_end = 1'b0;
		settle();
		rdchk(STAT_ADDR, exp);
	endtask : pass

	task automatic t_reset();
		rdchk(CFG_ADDR, 32'h0000_5020);
		rdchk(STAT_ADDR, 32'h0000_0000);
		chk({cur_a_gain, cur_b_gain}, 8'h11);
		mesc_cpu_model_inst.wr(STAT_ADDR, 32'hffff_ffff);
		rdchk(STAT_ADDR, 32'h0000_0000);
		rdchk(8'h7f, 32'h0000_0000);
	endtask : t_reset

	task automatic t_dip();
		cfg(32'h0006_0220);
		smp(LO, HI);
		pass(32'h1000_0000);
		smp(LO, HI);
		pass(32'h1200_0000);
		chk(aux_pulse_output, 1'b1);
		cfg(32'h000e_0220);
		chk(aux_pulse_output, 1'b0);
		smp(LO, LO);
		smp(LO, LO);
		pass(32'h1600_0000);
		chk(aux_pulse_output, 1'b1);
		smp(HI, HI);
		pass(32'h1000_0000);
		chk(aux_pulse_output, 1'b0);
		cfg(32'h0000_5060);
		chk(pll_phase_b, 1'b1);
		smp(LO, -HI);
		pass(32'h0000_0000);
		cfg(32'h0000_5020);
		chk(pll_phase_b, 1'b0);
		// routing bit clear: the pin shows its normal level
		aux_pin_normal = 1'b1;
		settle();
		chk(aux_pulse_output, 1'b1);
		aux_pin_normal = 1'b0;
		settle();
		chk(aux_pulse_output, 1'b0);
	endtask : t_dip

	task automatic t_path();
		cfg(32'h0000_5024);
		chk({cur_a_gain, cur_b_gain}, 8'h81);
		cfg(32'h0000_5028);
		chk({cur_a_gain, cur_b_gain}, 8'h18);
		for (int k = 0; k < 4; k++) begin
			mesc_cpu_model_inst.wr(RATE_ADDR + 8'(k), 32'h0000_0100 + 32'(k));
		end
		settle();
		for (int k = 0; k < 4; k++) begin
			chk(pulse_in[k], 32'h0000_0100 + 32'(k));
		end
		cfg(32'h0000_5022);
		chk(pulse_in[0], 32'h0000_1000);
		sums = '{32'h0a, 32'h14, 32'h03, 32'h04, 32'h05, 32'h09};
		meter_formula_select = 3'h2;
		cfg(32'h0000_5000);
		chk(pulse_in[0], 32'h0000_001e);
		chk(pulse_in[1], 32'h0000_0007);
		meter_formula_select = 3'h0;
		settle();
		chk(pulse_in[0], 32'h0000_0014);
	endtask : t_path

	task automatic t_temp();
		temp_offset       = 16'sh0004;
		temp_coeff_linear = 16'sh0100;
		// fresh phase a sample: last one was taken with phase b picked
		smp(HI, HI);
		pass(32'h1000_0000);
		chk(scale_factor_word, 32'h0000_4004);
		cfg(32'h0001_5020);
		mesc_cpu_model_inst.wr(GAIN_ADDR, 32'h0000_1234);
		settle();
		chk(scale_factor_word, 32'h0000_1234);
		// engine must leave a processor-owned word alone at pass end
		pass(32'h1000_0000);
		chk(scale_factor_word, 32'h0000_1234);
	endtask : t_temp

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		mismatches           = 0;
		tests_run            = 0;
		resetn               = 1'b0;
		pass_end             = 1'b0;
		smp_valid            = 1'b0;
		aux_pin_normal       = 1'b0;
		volt_a               = HI;
		volt_b               = HI;
		temp_offset          = 16'sh0000;
		temp_coeff_linear    = 16'sh0000;
		temp_coeff_quadratic = 16'sh0000;
		meter_formula_select = 3'h2;
		sums                 = '0;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		t_reset();
		t_dip();
		t_path();
		t_temp();
		finish_test();
	end

	// whole run needs well under 2000 cycles
	initial begin
		#20us;
		mismatches++;
		finish_test();
	end
endmodule : test_meter_engine_status_config
